// *** rtl/itm_timing_model.sv ***
// instruction timing model: per-instruction time, cycles, loops and latency limits
// Contract
// (R01) two-operand non-move: source time plus destination time plus execute-fetch time
// (R02) move: source time plus execute-fetch, no destination term
// (R03) single operand: destination plus execute-fetch; previous-space moves: execute-fetch only
// (R04) branch, jump, control, trap, misc: listed instruction time only
// (R05) byte ops match word times except where an explicit adder applies
// (R06) model excludes request servicing; assumes fast private memory sync path
// (R07) slow master sync path adds fixed penalty per memory cycle
// (R08) memory management adds fixed increment per memory cycle
// (R09) source address time and cycles looked up per source mode
// (R10) odd byte with source modes 1 to 7 adds fixed source amount
// (R11) destination time and cycles per mode; move and jumps skip it
// (R12) alternate destination times for add-like ops with source mode 0
// (R13) two-operand execute-fetch per form; subtract longer; odd byte memory adder
// (R14) move execute-fetch depends on destination, source mode and byte
// (R15) single operand execute-fetch per mode; shifts right slower; odd adder
// (R16) byte shift-right forms add extra fixed amount, odd or even
// (R17) previous-space moves exist only with memory management; fixed times
// (R18) branches longer when taken; subtract-one-branch has own pair
// (R19) jump and subroutine jump times per destination modes 1 to 7
// (R20) control ops fixed; bus reset lasts milliseconds; trap group five cycles
// (R21) halted: console polling loop of fixed period
// (R22) waiting: poll for interrupt request at fixed period
// (R23) interrupt requests acknowledged only at end of instruction; the code also acknowledges at wait_poll
// (R24) acknowledgement to service routine bounded
// (R25) first dma requester granted mastership within bounded latency
// (R26) times in hundredths of microsecond, cycles reported alongside
`timescale 1ns/1ps
module itm_timing_model #(
	parameter int RESET_CYCLES = itm_pkg::RESET_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic instr_valid,
	input wire itm_pkg::itm_instr_t instr,
	input wire logic mmu_present,
	input wire logic slow_sync,
	input wire logic halted,
	input wire logic waiting,
	input wire logic interrupt_bus_request,
	input wire logic nonprocessor_dma_request,
	output logic result_valid,
	output itm_pkg::itm_result_t result,
	output logic illegal_instr,
	output logic instr_end,
	output logic console_poll,
	output logic wait_poll,
	output logic interrupt_ack,
	output logic service_start,
	output logic dma_grant
);
	// ==========================================
	// address terms
	logic [itm_pkg::TW-1:0] src_t, dst_t, ef_t, tot_t, pen_t;
	logic [itm_pkg::CW-1:0] src_c, dst_c, ef_c, tot_c;
	logic odd, alt, use_src, use_dst, bad;
	logic [2:0] sm, dm;
	always_comb
	begin
		sm = instr.src_mode;
		dm = instr.dst_mode;
		odd = instr.is_byte && instr.odd_byte;
		// (R09) source per mode
		src_t = itm_pkg::T_SRC[sm];
		src_c = itm_pkg::C_SRC[sm];
		// (R10) odd source adder
		if (odd && sm != 3'h0)
			src_t = src_t + itm_pkg::T_ODD_SRC;
		// (R11) destination per mode
		alt = (instr.op == itm_pkg::OP_ADDLIKE || instr.op == itm_pkg::OP_SUB) && sm == 3'h0
			&& instr.cls == itm_pkg::CL_TWO_OP;
		dst_t = itm_pkg::T_DST_ALT[dm];
		// (R12) alternate column
		if (!alt)
			dst_t = itm_pkg::T_SRC[dm];
		dst_c = itm_pkg::C_DST[dm];
		// (R12) odd destination adder
		if (odd && dm != 3'h0)
			dst_t = dst_t + itm_pkg::T_ODD_DST;
	end
	// ==========================================
	// execute-fetch and totals
	always_comb
	begin
		ef_t = '0;
		ef_c = itm_pkg::C_ONE;
		use_src = 1'b0;
		use_dst = 1'b0;
		bad = 1'b0;
		case (instr.cls)
			itm_pkg::CL_TWO_OP:
			begin
				// (R01) all three terms
				use_src = 1'b1;
				use_dst = 1'b1;
				// (R13) two-operand forms
				if (dm == 3'h0)
				begin
					ef_t = itm_pkg::T_EF2_REG;
					if (sm != 3'h0 && instr.op != itm_pkg::OP_XOR)
						ef_t = itm_pkg::T_EF2_SRCMEM;
				end
				else
				begin
					ef_c = itm_pkg::C_TWO;
					ef_t = (instr.op == itm_pkg::OP_SUB) ? itm_pkg::T_EF2_SUB_MEM : itm_pkg::T_EF2_MEM;
					if (odd)
						ef_t = ef_t + itm_pkg::T_ODD_EF;
				end
			end
			itm_pkg::CL_MOVE:
			begin
				// (R02) no destination term
				use_src = 1'b1;
				// (R14) move table
				ef_c = itm_pkg::C_MOV[dm];
				ef_t = instr.is_byte ? itm_pkg::T_MOV_B[dm] : itm_pkg::T_MOV_W[dm];
				if (sm == 3'h0)
				begin
					if (dm == 3'h0 && !instr.is_byte)
						ef_t = itm_pkg::T_MOV_W_00;
					else if (dm == 3'h6)
						ef_t = instr.is_byte ? itm_pkg::T_MOV_B_60 : itm_pkg::T_MOV_W_60;
					else if (dm == 3'h7)
						ef_t = instr.is_byte ? itm_pkg::T_MOV_B_70 : itm_pkg::T_MOV_W_70;
				end
			end
			itm_pkg::CL_ONE_OP:
			begin
				// (R03) destination plus execute-fetch
				use_dst = 1'b1;
				// (R15) single-operand forms
				if (dm == 3'h0)
				begin
					ef_t = itm_pkg::T_EF1_REG;
					if (instr.op == itm_pkg::OP_SHR)
						ef_t = itm_pkg::T_EF1_SHR_REG;
					else if (instr.op == itm_pkg::OP_SXT)
						ef_t = itm_pkg::T_EF1_SXT_REG;
				end
				else
				begin
					ef_c = itm_pkg::C_TWO;
					ef_t = (instr.op == itm_pkg::OP_SHR) ? itm_pkg::T_EF1_SHR_MEM : itm_pkg::T_EF1_MEM;
					if (odd)
						ef_t = ef_t + itm_pkg::T_ODD_EF;
				end
				// (R16) byte shift-right adder
				if (instr.op == itm_pkg::OP_SHR && instr.is_byte)
					ef_t = ef_t + itm_pkg::T_SHR_BYTE;
			end
			itm_pkg::CL_PREV_FROM, itm_pkg::CL_PREV_TO:
			begin
				// (R17) only with memory management
				bad = !mmu_present;
				ef_c = itm_pkg::C_PREV;
				ef_t = (instr.cls == itm_pkg::CL_PREV_FROM) ? itm_pkg::T_MFP : itm_pkg::T_MTP;
			end
			itm_pkg::CL_BRANCH:
				// (R18) taken vs not taken
				ef_t = instr.taken ? itm_pkg::T_BR_TAKEN : itm_pkg::T_BR_NOT;
			itm_pkg::CL_SOB:
				ef_t = instr.taken ? itm_pkg::T_SOB_TAKEN : itm_pkg::T_SOB_NOT;
			itm_pkg::CL_JUMP:
			begin
				// (R19) jump per mode, mode 0 illegal
				bad = dm == 3'h0;
				ef_t = itm_pkg::T_JMP[dm];
				ef_c = itm_pkg::C_JMP[dm];
			end
			itm_pkg::CL_JSR:
			begin
				bad = dm == 3'h0;
				ef_t = itm_pkg::T_JSR[dm];
				ef_c = itm_pkg::C_JMP[dm] + itm_pkg::C_ONE;
			end
			// (R20) fixed control times
			itm_pkg::CL_RTS:
			begin
				ef_t = itm_pkg::T_RTS;
				ef_c = itm_pkg::C_TWO;
			end
			itm_pkg::CL_MARK:
			begin
				ef_t = itm_pkg::T_MARK;
				ef_c = itm_pkg::C_TWO;
			end
			itm_pkg::CL_RTI:
			begin
				ef_t = itm_pkg::T_RTI;
				ef_c = itm_pkg::C_THREE;
			end
			itm_pkg::CL_CC:
				ef_t = instr.cc_set ? itm_pkg::T_SETCC : itm_pkg::T_CLRCC;
			itm_pkg::CL_HALT:
				ef_t = itm_pkg::T_HALT;
			itm_pkg::CL_WAIT:
				ef_t = itm_pkg::T_WAIT;
			itm_pkg::CL_MISC:
			begin
				if (instr.trap)
				begin
					ef_t = itm_pkg::T_TRAP;
					ef_c = itm_pkg::C_TRAP;
				end
				else if (instr.reset_op)
					ef_t = itm_pkg::T_RESET_FLAG;
				else
					bad = 1'b1;
			end
			default:
				bad = 1'b1;
		endcase
	end
	always_comb
	begin
		// (R04) only listed time for non-operand classes
		tot_t = ef_t;
		tot_c = ef_c;
		if (use_src)
		begin
			tot_t = tot_t + src_t;
			tot_c = tot_c + src_c;
		end
		// (R05) byte ops reach word figures unless an adder applied above, except moves, which take T_MOV_B
		if (use_dst)
		begin
			tot_t = tot_t + dst_t;
			tot_c = tot_c + dst_c;
		end
		// (R06) servicing excluded; fast path is the base
		pen_t = '0;
		// (R07) slow sync per cycle
		if (slow_sync)
			pen_t = pen_t + itm_pkg::TW'(tot_c) * itm_pkg::T_SLOW_SYNC;
		// (R08) memory management per cycle
		if (mmu_present)
			pen_t = pen_t + itm_pkg::TW'(tot_c) * itm_pkg::T_MMU;
	end
	// ==========================================
	// result register
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			result_valid <= 1'b0;
			result <= '0;
			illegal_instr <= 1'b0;
		end
		else
		begin
			result_valid <= instr_valid && !bad;
			illegal_instr <= instr_valid && bad;
			if (instr_valid && !bad)
			begin
				// (R26) hundredths and cycles together
				result.cycles <= tot_c;
				result.long_reset <= instr.cls == itm_pkg::CL_MISC && instr.reset_op;
				// (R20) bus reset marked long, time not held
				result.time_hund <= (instr.cls == itm_pkg::CL_MISC && instr.reset_op) ? '0 : tot_t + pen_t;
			end
		end
	end
	// ==========================================
	// instruction pacing: one count per cycle, a hundredth is a fraction of it
	logic [31:0] run_q;
	logic busy_q;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			run_q <= '0;
			busy_q <= 1'b0;
		end
		else if (result_valid && !busy_q)
		begin
			busy_q <= 1'b1;
			run_q <= result.long_reset ? 32'(RESET_CYCLES) : 32'((32'(result.time_hund) * itm_pkg::CLK_MHZ) / 100);
		end
		else if (busy_q)
		begin
			if (run_q <= 32'h1)
				busy_q <= 1'b0;
			else
				run_q <= run_q - 32'h1;
		end
	end
	assign instr_end = busy_q && run_q <= 32'h1;
	// ==========================================
	// console and wait polling loops
	logic [7:0] halt_cnt_q, wait_cnt_q;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			halt_cnt_q <= '0;
		// (R21) console loop period
		else if (!halted || halt_cnt_q == 8'(itm_pkg::HALT_LOOP_CYC - 1))
			halt_cnt_q <= '0;
		else
			halt_cnt_q <= halt_cnt_q + 8'h1;
	end
	assign console_poll = halted && halt_cnt_q == 8'(itm_pkg::HALT_LOOP_CYC - 1);
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			wait_cnt_q <= '0;
		// (R22) wait loop period
		else if (!waiting || wait_cnt_q == 8'(itm_pkg::WAIT_LOOP_CYC - 1))
			wait_cnt_q <= '0;
		else
			wait_cnt_q <= wait_cnt_q + 8'h1;
	end
	assign wait_poll = waiting && wait_cnt_q == 8'(itm_pkg::WAIT_LOOP_CYC - 1);
	// ==========================================
	// interrupt acknowledge and service
	logic [7:0] svc_cnt_q;
	logic svc_q;
	// (R23) ack at instruction end or wait poll
	assign interrupt_ack = interrupt_bus_request && !svc_q && (instr_end || wait_poll);
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			svc_q <= 1'b0;
			svc_cnt_q <= '0;
		end
		else if (interrupt_ack)
		begin
			svc_q <= 1'b1;
			svc_cnt_q <= 8'(itm_pkg::IRQ_SERVICE_CYC - 1);
		end
		// (R24) bounded service time
		else if (svc_q)
		begin
			if (svc_cnt_q == 8'h0)
				svc_q <= 1'b0;
			else
				svc_cnt_q <= svc_cnt_q - 8'h1;
		end
	end
	assign service_start = svc_q && svc_cnt_q == 8'h0;
	// ==========================================
	// dma grant at instruction end, when idle, or at the latency bound
	logic [7:0] dma_cnt_q;
	logic dma_grant_q;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dma_cnt_q <= '0;
			dma_grant_q <= 1'b0;
		end
		// (R25) grant within latency bound
		else if (!nonprocessor_dma_request)
		begin
			dma_cnt_q <= '0;
			dma_grant_q <= 1'b0;
		end
		else if (!dma_grant_q)
		begin
			if (instr_end || !busy_q || dma_cnt_q == 8'(itm_pkg::DMA_LAT_CYC - 2))
				dma_grant_q <= 1'b1;
			else
				dma_cnt_q <= dma_cnt_q + 8'h1;
		end
	end
	assign dma_grant = dma_grant_q;
endmodule

// *** shared/itm_pkg.sv ***
// package: timing tables, classes and carriers for the instruction timing model
package itm_pkg;
	// times in hundredths of a microsecond
	localparam int TW = 16;
	localparam int CW = 4;
	localparam int CLK_MHZ = 25;
	localparam int CYC_PER_HUND = CLK_MHZ / 4;
	// odd byte, byte shift-right and option adders
	localparam logic [TW-1:0] T_SLOW_SYNC = 16'h0008;
	localparam logic [TW-1:0] T_MMU = 16'h000f;
	localparam logic [TW-1:0] T_ODD_SRC = 16'h0022;
	localparam logic [TW-1:0] T_ODD_DST = 16'h0022;
	localparam logic [TW-1:0] T_ODD_EF = 16'h0030;
	localparam logic [TW-1:0] T_SHR_BYTE = 16'h000e;
	// src / dst address times per mode 0..7
	localparam logic [7:0][TW-1:0] T_SRC = {16'h00ec, 16'h0092, 16'h00ae, 16'h0054,
		16'h00ae, 16'h0054, 16'h004e, 16'h0000};
	localparam logic [7:0][CW-1:0] C_SRC = {4'h3, 4'h2, 4'h2, 4'h1, 4'h2, 4'h1, 4'h1, 4'h0};
	localparam logic [7:0][TW-1:0] T_DST_ALT = {16'h0108, 16'h00ae, 16'h00b4, 16'h005a,
		16'h00b4, 16'h005a, 16'h005a, 16'h0000};
	localparam logic [7:0][CW-1:0] C_DST = {4'h1, 4'h2, 4'h2, 4'h1, 4'h2, 4'h1, 4'h1, 4'h0};
	// two-operand execute-fetch
	localparam logic [TW-1:0] T_EF2_REG = 16'h0063;
	localparam logic [TW-1:0] T_EF2_SRCMEM = 16'h00a0;
	localparam logic [TW-1:0] T_EF2_MEM = 16'h00b0;
	localparam logic [TW-1:0] T_EF2_SUB_MEM = 16'h00be;
	// move execute-fetch, word and byte per dst mode (src mode 1..7 column)
	localparam logic [7:0][TW-1:0] T_MOV_W = {16'h0192, 16'h013e, 16'h013e, 16'h00f2,
		16'h013e, 16'h00f2, 16'h00f2, 16'h0092};
	localparam logic [7:0][TW-1:0] T_MOV_B = {16'h01a0, 16'h014c, 16'h014c, 16'h0100,
		16'h014c, 16'h0100, 16'h0100, 16'h00b4};
	localparam logic [TW-1:0] T_MOV_W_00 = 16'h005a;
	localparam logic [TW-1:0] T_MOV_W_60 = 16'h011c;
	localparam logic [TW-1:0] T_MOV_B_60 = 16'h012a;
	localparam logic [TW-1:0] T_MOV_W_70 = 16'h0170;
	localparam logic [TW-1:0] T_MOV_B_70 = 16'h017e;
	localparam logic [7:0][CW-1:0] C_MOV = {4'h4, 4'h3, 4'h3, 4'h2, 4'h3, 4'h2, 4'h2, 4'h0};
	// single-operand execute-fetch
	localparam logic [TW-1:0] T_EF1_REG = 16'h0063;
	localparam logic [TW-1:0] T_EF1_MEM = 16'h00b1;
	localparam logic [TW-1:0] T_EF1_SHR_REG = 16'h007d;
	localparam logic [TW-1:0] T_EF1_SHR_MEM = 16'h00ce;
	localparam logic [TW-1:0] T_EF1_SXT_REG = 16'h005a;
	localparam logic [TW-1:0] T_MFP = 16'h0176;
	localparam logic [TW-1:0] T_MTP = 16'h0170;
	localparam logic [CW-1:0] C_PREV = 4'h2;
	// branches
	localparam logic [TW-1:0] T_BR_TAKEN = 16'h00b0;
	localparam logic [TW-1:0] T_BR_NOT = 16'h008c;
	localparam logic [TW-1:0] T_SOB_TAKEN = 16'h00ec;
	localparam logic [TW-1:0] T_SOB_NOT = 16'h00cc;
	// jumps, modes 1..7 at index 1..7
	localparam logic [7:0][TW-1:0] T_JMP = {16'h0124, 16'h00ec, 16'h00e6, 16'h00be,
		16'h00e6, 16'h00d2, 16'h00b4, 16'h0000};
	localparam logic [7:0][TW-1:0] T_JSR = {16'h0196, 16'h015e, 16'h0158, 16'h0130,
		16'h0158, 16'h0144, 16'h0126, 16'h0000};
	localparam logic [7:0][CW-1:0] C_JMP = {4'h3, 4'h2, 4'h2, 4'h1, 4'h2, 4'h1, 4'h1, 4'h0};
	// control and misc
	localparam logic [TW-1:0] T_RTS = 16'h00f2;
	localparam logic [TW-1:0] T_MARK = 16'h0100;
	localparam logic [TW-1:0] T_RTI = 16'h0124;
	localparam logic [TW-1:0] T_SETCC = 16'h00ac;
	localparam logic [TW-1:0] T_CLRCC = 16'h00ca;
	localparam logic [TW-1:0] T_HALT = 16'h00f2;
	localparam logic [TW-1:0] T_WAIT = 16'h00e0;
	localparam logic [TW-1:0] T_TRAP = 16'h0244;
	localparam logic [CW-1:0] C_TRAP = 4'h5;
	localparam logic [CW-1:0] C_TWO = 4'h2;
	localparam logic [CW-1:0] C_THREE = 4'h3;
	localparam logic [CW-1:0] C_ONE = 4'h1;
	// reset instruction 80 ms, flagged long in the result with time zero; paced as RESET_CYC clock cycles
	localparam int RESET_MS = 80;
	localparam logic [TW-1:0] T_RESET_FLAG = 16'hffff;
	// loops and latency limits, hundredths of a us
	localparam int HALT_LOOP_HUND = 44;
	localparam int WAIT_LOOP_HUND = 112;
	localparam int IRQ_SERVICE_HUND = 542;
	localparam int DMA_LAT_HUND = 350;
	localparam int HALT_LOOP_CYC = HALT_LOOP_HUND * CLK_MHZ / 100;
	localparam int WAIT_LOOP_CYC = WAIT_LOOP_HUND * CLK_MHZ / 100;
	localparam int IRQ_SERVICE_CYC = IRQ_SERVICE_HUND * CLK_MHZ / 100;
	localparam int DMA_LAT_CYC = DMA_LAT_HUND * CLK_MHZ / 100;
	localparam int RESET_CYC = RESET_MS * 1000 * CLK_MHZ;
	localparam int HUND_CYC = 1;

	typedef enum logic [3:0] {
		CL_TWO_OP, CL_MOVE, CL_ONE_OP, CL_PREV_FROM, CL_PREV_TO, CL_BRANCH, CL_SOB,
		CL_JUMP, CL_JSR, CL_RTS, CL_MARK, CL_RTI, CL_CC, CL_HALT, CL_WAIT, CL_MISC
	} itm_class_t;

	typedef enum logic [2:0] {
		OP_ADDLIKE, OP_SUB, OP_XOR, OP_PLAIN, OP_SHR, OP_SXT, OP_OTHER
	} itm_op_t;

	typedef struct packed {
		itm_class_t cls;
		itm_op_t op;
		logic [2:0] src_mode;
		logic [2:0] dst_mode;
		logic is_byte;
		logic odd_byte;
		logic taken;
		logic cc_set;
		logic trap;
		logic reset_op;
	} itm_instr_t;

	typedef struct packed {
		logic [TW-1:0] time_hund;
		logic [CW-1:0] cycles;
		logic long_reset;
	} itm_result_t;
endpackage

// *** tb/itm_props.sv ***
// checker: port relations of the instruction timing model
`timescale 1ns/1ps
module itm_props #(
	parameter int RESET_CYCLES = itm_pkg::RESET_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic instr_valid,
	input wire itm_pkg::itm_instr_t instr,
	input wire logic mmu_present,
	input wire logic slow_sync,
	input wire logic halted,
	input wire logic waiting,
	input wire logic interrupt_bus_request,
	input wire logic nonprocessor_dma_request,
	input wire logic result_valid,
	input wire itm_pkg::itm_result_t result,
	input wire logic illegal_instr,
	input wire logic instr_end,
	input wire logic console_poll,
	input wire logic wait_poll,
	input wire logic interrupt_ack,
	input wire logic service_start,
	input wire logic dma_grant
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// ==========
	// sequences
	sequence s_quiet;
		!console_poll [*8];
	endsequence
	sequence s_plain;
		instr_valid && !slow_sync && !mmu_present;
	endsequence
	// ==========
	// properties
	property p_answer;
		instr_valid |=> result_valid ^ illegal_instr;
	endproperty
	property p_idle;
		!instr_valid |=> !result_valid && !illegal_instr;
	endproperty
	property p_jump0;
		instr_valid && (instr.cls == itm_pkg::CL_JUMP || instr.cls == itm_pkg::CL_JSR) && instr.dst_mode == 3'h0
			|=> illegal_instr;
	endproperty
	property p_prev;
		instr_valid && !mmu_present && (instr.cls == itm_pkg::CL_PREV_FROM || instr.cls == itm_pkg::CL_PREV_TO)
			|=> illegal_instr;
	endproperty
	property p_branch;
		s_plain ##0 instr.cls == itm_pkg::CL_BRANCH
			|=> result.time_hund == ($past(instr.taken) ? 16'h00b0 : 16'h008c) && result.cycles == 4'h1;
	endproperty
	property p_penalty;
		instr_valid && slow_sync && mmu_present && instr.cls == itm_pkg::CL_BRANCH
			|=> result.time_hund == ($past(instr.taken) ? 16'h00c7 : 16'h00a3);
	endproperty
	property p_trap;
		s_plain ##0 (instr.cls == itm_pkg::CL_MISC && instr.trap)
			|=> result.time_hund == 16'h0244 && result.cycles == 4'h5;
	endproperty
	property p_long;
		instr_valid && instr.cls == itm_pkg::CL_MISC && instr.reset_op |=> result.long_reset;
	endproperty
	property p_ack;
		interrupt_ack |-> instr_end || wait_poll;
	endproperty
	property p_service;
		interrupt_ack |-> ##135 service_start;
	endproperty
	property p_dma;
		$rose(nonprocessor_dma_request) |-> ##[1:87] dma_grant;
	endproperty
	property p_console;
		console_poll |=> s_quiet ##3 (console_poll || !halted);
	endproperty
	property p_wait;
		wait_poll |-> ##28 (wait_poll || !waiting);
	endproperty
	a_answer: assert property (p_answer) else $error("no single answer");
	a_idle: assert property (p_idle) else $error("answer without request");
	a_jump0: assert property (p_jump0) else $error("jump mode 0 accepted");
	a_prev: assert property (p_prev) else $error("previous space move without mmu");
	a_branch: assert property (p_branch) else $error("branch time wrong");
	a_penalty: assert property (p_penalty) else $error("penalised branch wrong");
	a_trap: assert property (p_trap) else $error("trap time wrong");
	a_long: assert property (p_long) else $error("bus reset not long");
	a_ack: assert property (p_ack) else $error("ack mid instruction");
	a_service: assert property (p_service) else $error("service start late");
	a_dma: assert property (p_dma) else $error("dma grant late");
	a_console: assert property (p_console) else $error("console loop period");
	a_wait: assert property (p_wait) else $error("wait loop period");
endmodule

bind itm_timing_model itm_props #(
	.RESET_CYCLES(RESET_CYCLES)
) u_props (
	.clk(clk),
	.sys_rst(sys_rst),
	.instr_valid(instr_valid),
	.instr(instr),
	.mmu_present(mmu_present),
	.slow_sync(slow_sync),
	.halted(halted),
	.waiting(waiting),
	.interrupt_bus_request(interrupt_bus_request),
	.nonprocessor_dma_request(nonprocessor_dma_request),
	.result_valid(result_valid),
	.result(result),
	.illegal_instr(illegal_instr),
	.instr_end(instr_end),
	.console_poll(console_poll),
	.wait_poll(wait_poll),
	.interrupt_ack(interrupt_ack),
	.service_start(service_start),
	.dma_grant(dma_grant)
);

// *** tb/itm_bus_model.sv ***
// partner: interrupt and dma requesters on the system bus
`timescale 1ns/1ps
module itm_bus_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic irq_go,
	input wire logic dma_go,
	input wire logic [7:0] dma_hold,
	input wire logic interrupt_ack,
	input wire logic dma_grant,
	output logic interrupt_bus_request,
	output logic nonprocessor_dma_request
);
	logic [7:0] hold_q;
	// request held until acknowledged
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			interrupt_bus_request <= 1'b0;
		else if (irq_go)
			interrupt_bus_request <= 1'b1;
		else if (interrupt_ack)
			interrupt_bus_request <= 1'b0;
	end
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			nonprocessor_dma_request <= 1'b0;
			hold_q <= 8'h00;
		end
		else if (dma_go)
		begin
			nonprocessor_dma_request <= 1'b1;
			hold_q <= dma_hold;
		end
		else if (nonprocessor_dma_request && dma_grant)
		begin
			if (hold_q == 8'h00)
				nonprocessor_dma_request <= 1'b0;
			hold_q <= hold_q - 8'h01;
		end
	end
endmodule

// *** tb/tb_top.sv ***
// testbench: instruction timing model against the timing tables
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic instr_valid = 1'b0;
	itm_pkg::itm_instr_t instr = '0;
	logic mmu_present = 1'b0;
	logic slow_sync = 1'b0;
	logic halted = 1'b0;
	logic waiting = 1'b0;
	logic irq_go = 1'b0;
	logic dma_go = 1'b0;
	logic [7:0] dma_hold = 8'h00;
	logic interrupt_bus_request, nonprocessor_dma_request, result_valid, illegal_instr, instr_end;
	logic console_poll, wait_poll, interrupt_ack, service_start, dma_grant;
	itm_pkg::itm_result_t result;
	int miscompares = 0;
	int num_checks = 0;
	always #20 clk = ~clk;
	itm_timing_model #(.RESET_CYCLES(20)) DUT (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
		.instr(instr), .mmu_present(mmu_present), .slow_sync(slow_sync), .halted(halted), .waiting(waiting),
		.interrupt_bus_request(interrupt_bus_request), .nonprocessor_dma_request(nonprocessor_dma_request),
		.result_valid(result_valid), .result(result), .illegal_instr(illegal_instr), .instr_end(instr_end),
		.console_poll(console_poll), .wait_poll(wait_poll), .interrupt_ack(interrupt_ack),
		.service_start(service_start), .dma_grant(dma_grant));
	itm_bus_model u_bus (.clk(clk), .sys_rst(sys_rst), .irq_go(irq_go), .dma_go(dma_go), .dma_hold(dma_hold),
		.interrupt_ack(interrupt_ack), .dma_grant(dma_grant), .interrupt_bus_request(interrupt_bus_request),
		.nonprocessor_dma_request(nonprocessor_dma_request));
	// ==========
	// helpers
	task automatic tally_and_finish();
		if (miscompares == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask
	// flags: byte, odd, taken, cc set, trap, reset
	function automatic itm_pkg::itm_instr_t mk(input itm_pkg::itm_class_t c, input itm_pkg::itm_op_t o,
		input logic [2:0] s, input logic [2:0] d, input logic [5:0] f);
		mk = {c, o, s, d, f};
	endfunction
	task automatic send(input itm_pkg::itm_instr_t i);
		@(negedge clk);
		instr_valid = 1'b1;
		instr = i;
		@(negedge clk);
		instr_valid = 1'b0;
	endtask
	task automatic run(input itm_pkg::itm_instr_t i, input logic [15:0] t, input logic [3:0] c);
		send(i);
		chk("result_valid", 16'h0001, 16'(result_valid));
		chk("time_hund", t, result.time_hund);
		chk("cycles", 16'(c), 16'(result.cycles));
	endtask
	task automatic bad(input itm_pkg::itm_instr_t i);
		send(i);
		chk("illegal_instr", 16'h0001, 16'(illegal_instr));
		chk("result_valid", 16'h0000, 16'(result_valid));
	endtask
	function automatic logic sig(input int w);
		case (w)
			0: sig = console_poll;
			1: sig = wait_poll;
			2: sig = interrupt_ack;
			3: sig = service_start;
			default: sig = dma_grant;
		endcase
	endfunction
	task automatic wait_for(input int w, output int n);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end while (sig(w) !== 1'b1 && n < 400);
	endtask
	// ==========
	// scenarios
	task automatic t_two_op();
		run(mk(itm_pkg::CL_TWO_OP, itm_pkg::OP_ADDLIKE, 3'h2, 3'h3, 6'h00), 16'h01b2, 4'h5);
		run(mk(itm_pkg::CL_TWO_OP, itm_pkg::OP_SUB, 3'h0, 3'h0, 6'h00), 16'h0063, 4'h1);
		run(mk(itm_pkg::CL_TWO_OP, itm_pkg::OP_SUB, 3'h1, 3'h1, 6'h00), 16'h015a, 4'h4);
		run(mk(itm_pkg::CL_TWO_OP, itm_pkg::OP_ADDLIKE, 3'h0, 3'h1, 6'h00), 16'h010a, 4'h3);
		run(mk(itm_pkg::CL_TWO_OP, itm_pkg::OP_ADDLIKE, 3'h1, 3'h1, 6'h30), 16'h01c0, 4'h4);
	endtask
	task automatic t_penalty();
		slow_sync = 1'b1;
		mmu_present = 1'b1;
		run(mk(itm_pkg::CL_TWO_OP, itm_pkg::OP_ADDLIKE, 3'h0, 3'h1, 6'h00), 16'h014f, 4'h3);
		run(mk(itm_pkg::CL_BRANCH, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h08), 16'h00c7, 4'h1);
		slow_sync = 1'b0;
		run(mk(itm_pkg::CL_PREV_FROM, itm_pkg::OP_OTHER, 3'h0, 3'h1, 6'h00), 16'h0194, 4'h2);
		run(mk(itm_pkg::CL_PREV_TO, itm_pkg::OP_OTHER, 3'h0, 3'h1, 6'h00), 16'h018e, 4'h2);
		mmu_present = 1'b0;
		bad(mk(itm_pkg::CL_PREV_FROM, itm_pkg::OP_OTHER, 3'h0, 3'h1, 6'h00));
	endtask
	task automatic t_move_one();
		run(mk(itm_pkg::CL_MOVE, itm_pkg::OP_PLAIN, 3'h0, 3'h0, 6'h00), 16'h005a, 4'h0);
		run(mk(itm_pkg::CL_MOVE, itm_pkg::OP_PLAIN, 3'h1, 3'h7, 6'h30), 16'h0210, 4'h5);
		run(mk(itm_pkg::CL_MOVE, itm_pkg::OP_PLAIN, 3'h0, 3'h6, 6'h20), 16'h012a, 4'h3);
		run(mk(itm_pkg::CL_ONE_OP, itm_pkg::OP_SHR, 3'h0, 3'h2, 6'h30), 16'h0182, 4'h3);
		run(mk(itm_pkg::CL_ONE_OP, itm_pkg::OP_SHR, 3'h0, 3'h0, 6'h00), 16'h007d, 4'h1);
		run(mk(itm_pkg::CL_ONE_OP, itm_pkg::OP_PLAIN, 3'h0, 3'h1, 6'h00), 16'h00ff, 4'h3);
		run(mk(itm_pkg::CL_ONE_OP, itm_pkg::OP_SXT, 3'h0, 3'h0, 6'h00), 16'h005a, 4'h1);
	endtask
	task automatic t_flow();
		run(mk(itm_pkg::CL_BRANCH, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h00), 16'h008c, 4'h1);
		run(mk(itm_pkg::CL_SOB, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h08), 16'h00ec, 4'h1);
		run(mk(itm_pkg::CL_SOB, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h00), 16'h00cc, 4'h1);
		run(mk(itm_pkg::CL_JUMP, itm_pkg::OP_OTHER, 3'h0, 3'h1, 6'h00), 16'h00b4, 4'h1);
		bad(mk(itm_pkg::CL_JUMP, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h00));
		run(mk(itm_pkg::CL_RTS, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h00), 16'h00f2, 4'h2);
		run(mk(itm_pkg::CL_MARK, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h00), 16'h0100, 4'h2);
		run(mk(itm_pkg::CL_RTI, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h00), 16'h0124, 4'h3);
		run(mk(itm_pkg::CL_CC, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h04), 16'h00ac, 4'h1);
		run(mk(itm_pkg::CL_CC, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h00), 16'h00ca, 4'h1);
		run(mk(itm_pkg::CL_HALT, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h00), 16'h00f2, 4'h1);
		run(mk(itm_pkg::CL_WAIT, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h00), 16'h00e0, 4'h1);
		bad(mk(itm_pkg::CL_MISC, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h00));
		send(mk(itm_pkg::CL_MISC, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h01));
		chk("long_reset", 16'h0001, 16'(result.long_reset));
		run(mk(itm_pkg::CL_MISC, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h02), 16'h0244, 4'h5);
	endtask
	task automatic t_loops();
		int n;
		halted = 1'b1;
		wait_for(0, n);
		wait_for(0, n);
		chk("console gap", 16'h000b, 16'(n));
		halted = 1'b0;
		waiting = 1'b1;
		wait_for(1, n);
		wait_for(1, n);
		chk("wait gap", 16'h001c, 16'(n));
		irq_go = 1'b1;
		@(negedge clk);
		irq_go = 1'b0;
		wait_for(2, n);
		chk("wait_poll at ack", 16'h0001, 16'(wait_poll));
		wait_for(3, n);
		chk("service delay", 16'h0087, 16'(n));
		waiting = 1'b0;
		run(mk(itm_pkg::CL_JSR, itm_pkg::OP_OTHER, 3'h0, 3'h7, 6'h00), 16'h0196, 4'h4);
		irq_go = 1'b1;
		@(negedge clk);
		irq_go = 1'b0;
		wait_for(2, n);
		chk("instr_end at ack", 16'h0001, 16'(instr_end));
		wait_for(3, n);
	endtask
	task automatic t_dma();
		int n;
		for (int k = 0; k < 2; k++)
		begin
			dma_hold = (k == 0) ? 8'h10 : 8'h00;
			if (k == 1)
				send(mk(itm_pkg::CL_MISC, itm_pkg::OP_OTHER, 3'h0, 3'h0, 6'h02));
			dma_go = 1'b1;
			@(negedge clk);
			dma_go = 1'b0;
			wait_for(4, n);
			chk("dma latency bound", 16'h0001, 16'(n <= 87));
			repeat (24) @(negedge clk);
			chk("dma_grant released", 16'h0000, 16'(dma_grant));
		end
	endtask
	// ==========
	// main sequence and watchdog
	initial
	begin
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		t_two_op();
		t_penalty();
		t_move_one();
		t_flow();
		t_loops();
		t_dma();
		tally_and_finish();
	end
	initial
	begin
		#2000000;
		miscompares++;
		tally_and_finish();
	end
endmodule
